// file: common/caf_defs.svh
`ifndef CAF_DEFS_SVH
`define CAF_DEFS_SVH

// Register regions and offsets (word addresses on the register port)
`define CAF_FSTD_REGION   4'h0
`define CAF_FEXT_REGION   4'h1
`define CAF_MSTD_GROUP    6'h08
`define CAF_MEXT_GROUP    6'h09
`define CAF_BPTR_GROUP    6'h0b
`define CAF_MSEL_LO_OFF   8'h28
`define CAF_MSEL_HI_OFF   8'h29
`define CAF_FEN_OFF       8'h2a
`define CAF_RXFULL_OFF    8'h30
`define CAF_STATUS_OFF    8'h31

// Standard identifier word layout
`define CAF_SID_MSB       15
`define CAF_SID_LSB       5
`define CAF_TYPE_BIT      3
`define CAF_EIDHI_MSB     1
`define CAF_EIDHI_LSB     0
`define CAF_STD_WMASK     16'hffeb
`define CAF_STD_CMPMASK   16'hffe3

// Reset values
`define CAF_ID_RST        16'h0000
`define CAF_MSEL_RST      16'h0000
`define CAF_FEN_RST       16'hffff
`define CAF_BPTR_RST      16'h0000
`define CAF_RXFULL_RST    16'h0000

// Codes
`define CAF_MSRC_RSVD     2'h3
`define CAF_DEST_FIFO     4'hf

`endif

// file: common/caf_pkg.sv
package caf_pkg;
  typedef logic [15:0] caf_word_t;
  typedef logic [7:0]  caf_addr_t;
  typedef logic [3:0]  caf_idx_t;
  typedef enum logic [1:0] {
    CAF_MASK0 = 2'h0,
    CAF_MASK1 = 2'h1,
    CAF_MASK2 = 2'h2,
    CAF_MASK_RSVD = 2'h3
  } caf_mask_src_t;
endpackage

// file: rtl/caf_match.sv
`timescale 1ns/1ps
`include "caf_defs.svh"
module caf_match #(
  parameter int NUM_FILT = 16,
  parameter int NUM_MASK = 3
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              nrst_in,
  // Register port
  input  wire caf_pkg::caf_addr_t reg_addr_in,
  input  wire caf_pkg::caf_word_t reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output caf_pkg::caf_word_t     reg_rdata_out,
  // Incoming message identifier from the receive path
  input  wire logic              rx_id_valid_in,
  input  wire logic [10:0]       rx_sid_in,
  input  wire logic [17:0]       rx_eid_in,
  input  wire logic              rx_ext_in,
  // Acceptance result
  output logic                   accept_valid_out,
  output logic                   reject_valid_out,
  output caf_pkg::caf_idx_t      accept_filter_out,
  output caf_pkg::caf_idx_t      accept_dest_out
);
  import caf_pkg::*;

  // Register storage
  caf_word_t filt_std_ff [NUM_FILT];
  caf_word_t filt_ext_ff [NUM_FILT];
  caf_word_t mask_std_ff [NUM_MASK];
  caf_word_t mask_ext_ff [NUM_MASK];
  caf_word_t nxt_filt_std [NUM_FILT];
  caf_word_t nxt_filt_ext [NUM_FILT];
  caf_word_t nxt_mask_std [NUM_MASK];
  caf_word_t nxt_mask_ext [NUM_MASK];
  caf_word_t mask_select_low_ff;
  caf_word_t mask_select_high_ff;
  caf_word_t filter_accept_enable_ff;
  caf_word_t bptr_ff [4];
  caf_word_t rx_buffer_full_flag_ff;
  caf_word_t nxt_mask_select_low;
  caf_word_t nxt_mask_select_high;
  caf_word_t nxt_filter_accept_enable;
  caf_word_t nxt_bptr [4];
  caf_word_t nxt_rx_buffer_full_flag;
  caf_word_t rdata_ff;
  caf_word_t nxt_rdata;

  // Match result registers
  logic      accept_ff;
  logic      reject_ff;
  caf_idx_t  filter_ff;
  caf_idx_t  dest_ff;
  logic      nxt_accept;
  logic      nxt_reject;
  caf_idx_t  nxt_filter;
  caf_idx_t  nxt_dest;
  caf_word_t status_ff;
  caf_word_t nxt_status;

  // Per-filter hit vector and flattened select fields
  logic [NUM_FILT-1:0] hit;
  logic [31:0]         msel_all;
  logic [63:0]         bptr_all;
  caf_word_t           msg_std;

  assign msel_all = {mask_select_high_ff, mask_select_low_ff};
  assign bptr_all = {bptr_ff[3], bptr_ff[2], bptr_ff[1], bptr_ff[0]};

  // Message laid out like a filter standard word so one XOR covers both
  assign msg_std = {rx_sid_in, 3'h0, rx_eid_in[17:16]};

  // Per-filter comparison against its selected mask
  for (genvar gi = 0; gi < NUM_FILT; gi++) begin : g_filt
    caf_mask_src_t src;
    caf_word_t     m_std;
    caf_word_t     m_ext;
    logic          std_ok;
    logic          ext_ok;
    logic          type_ok;
    always_comb begin
      src   = caf_mask_src_t'(msel_all[2*gi +: 2]);
      m_std = '0;
      m_ext = '0;
      unique case (src)
        CAF_MASK0: begin
          m_std = mask_std_ff[0];
          m_ext = mask_ext_ff[0];
        end
        CAF_MASK1: begin
          m_std = mask_std_ff[1];
          m_ext = mask_ext_ff[1];
        end
        CAF_MASK2: begin
          m_std = mask_std_ff[2];
          m_ext = mask_ext_ff[2];
        end
        CAF_MASK_RSVD: begin
          m_std = '0;
          m_ext = '0;
        end
      endcase
      // Masked XOR: only bits with a one in the mask can break the match
      std_ok = (((msg_std ^ filt_std_ff[gi]) & m_std & `CAF_STD_CMPMASK) == '0);
      ext_ok = (((rx_eid_in[15:0] ^ filt_ext_ff[gi]) & m_ext) == '0);
      if (m_std[`CAF_TYPE_BIT]) begin
        type_ok = (filt_std_ff[gi][`CAF_TYPE_BIT] == rx_ext_in);
      end else begin
        type_ok = 1'b1;
      end
      // Reserved source never hits, so a stray code cannot open a filter wide
      hit[gi] = filter_accept_enable_ff[gi] && (src != CAF_MASK_RSVD)
                && std_ok && ext_ok && type_ok;
    end
  end

  // Priority pick and result next values
  always_comb begin
    nxt_accept = 1'b0;
    nxt_reject = 1'b0;
    nxt_filter = filter_ff;
    nxt_dest   = dest_ff;
    nxt_status = status_ff;
    if (rx_id_valid_in) begin
      nxt_reject = ~|hit;
      // Scan downward so the lowest hitting index is the last to land
      for (int i = NUM_FILT - 1; i >= 0; i--) begin
        if (hit[i]) begin
          nxt_accept = 1'b1;
          nxt_filter = caf_idx_t'(i);
          nxt_dest   = bptr_all[4*i +: 4];
        end
      end
      nxt_status = {7'h00, nxt_accept, nxt_filter, nxt_dest};
    end
  end

  // Register writes, full flag set and clear
  always_comb begin
    nxt_filt_std             = filt_std_ff;
    nxt_filt_ext             = filt_ext_ff;
    nxt_mask_std             = mask_std_ff;
    nxt_mask_ext             = mask_ext_ff;
    nxt_mask_select_low      = mask_select_low_ff;
    nxt_mask_select_high     = mask_select_high_ff;
    nxt_filter_accept_enable = filter_accept_enable_ff;
    nxt_bptr                 = bptr_ff;
    nxt_rx_buffer_full_flag  = rx_buffer_full_flag_ff;
    if (reg_wr_in) begin
      if (reg_addr_in[7:4] == `CAF_FSTD_REGION) begin
        nxt_filt_std[reg_addr_in[3:0]] = reg_wdata_in & `CAF_STD_WMASK;
      end
      if (reg_addr_in[7:4] == `CAF_FEXT_REGION) begin
        nxt_filt_ext[reg_addr_in[3:0]] = reg_wdata_in;
      end
      if (reg_addr_in[7:2] == `CAF_MSTD_GROUP && reg_addr_in[1:0] != 2'h3) begin
        nxt_mask_std[reg_addr_in[1:0]] = reg_wdata_in & `CAF_STD_WMASK;
      end
      if (reg_addr_in[7:2] == `CAF_MEXT_GROUP && reg_addr_in[1:0] != 2'h3) begin
        nxt_mask_ext[reg_addr_in[1:0]] = reg_wdata_in;
      end
      if (reg_addr_in[7:2] == `CAF_BPTR_GROUP) begin
        nxt_bptr[reg_addr_in[1:0]] = reg_wdata_in;
      end
      if (reg_addr_in == `CAF_MSEL_LO_OFF) begin
        nxt_mask_select_low = reg_wdata_in;
      end
      if (reg_addr_in == `CAF_MSEL_HI_OFF) begin
        nxt_mask_select_high = reg_wdata_in;
      end
      if (reg_addr_in == `CAF_FEN_OFF) begin
        nxt_filter_accept_enable = reg_wdata_in;
      end
      // Clear only: a zero written clears, a one leaves the flag alone
      if (reg_addr_in == `CAF_RXFULL_OFF) begin
        nxt_rx_buffer_full_flag = rx_buffer_full_flag_ff & reg_wdata_in;
      end
    end
    // Set after clear so a fill in the clearing cycle is not lost
    if (accept_ff && dest_ff != `CAF_DEST_FIFO) begin
      nxt_rx_buffer_full_flag[dest_ff] = 1'b1;
    end
    nxt_rx_buffer_full_flag[15] = 1'b0; // Pointer 1111 is the queue, no buffer
  end

  // Read mux; data shows only in the cycle after the strobe
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd_in) begin
      if (reg_addr_in[7:4] == `CAF_FSTD_REGION) begin
        nxt_rdata = filt_std_ff[reg_addr_in[3:0]];
      end else if (reg_addr_in[7:4] == `CAF_FEXT_REGION) begin
        nxt_rdata = filt_ext_ff[reg_addr_in[3:0]];
      end else if (reg_addr_in[7:2] == `CAF_MSTD_GROUP && reg_addr_in[1:0] != 2'h3) begin
        nxt_rdata = mask_std_ff[reg_addr_in[1:0]];
      end else if (reg_addr_in[7:2] == `CAF_MEXT_GROUP && reg_addr_in[1:0] != 2'h3) begin
        nxt_rdata = mask_ext_ff[reg_addr_in[1:0]];
      end else if (reg_addr_in[7:2] == `CAF_BPTR_GROUP) begin
        nxt_rdata = bptr_ff[reg_addr_in[1:0]];
      end else if (reg_addr_in == `CAF_MSEL_LO_OFF) begin
        nxt_rdata = mask_select_low_ff;
      end else if (reg_addr_in == `CAF_MSEL_HI_OFF) begin
        nxt_rdata = mask_select_high_ff;
      end else if (reg_addr_in == `CAF_FEN_OFF) begin
        nxt_rdata = filter_accept_enable_ff;
      end else if (reg_addr_in == `CAF_RXFULL_OFF) begin
        nxt_rdata = rx_buffer_full_flag_ff;
      end else if (reg_addr_in == `CAF_STATUS_OFF) begin
        nxt_rdata = status_ff;
      end
    end
  end

  // Identifier and mask storage
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_FILT; i++) begin
        filt_std_ff[i] <= `CAF_ID_RST;
        filt_ext_ff[i] <= `CAF_ID_RST;
      end
      for (int i = 0; i < NUM_MASK; i++) begin
        mask_std_ff[i] <= `CAF_ID_RST;
        mask_ext_ff[i] <= `CAF_ID_RST;
      end
    end else begin
      filt_std_ff <= nxt_filt_std;
      filt_ext_ff <= nxt_filt_ext;
      mask_std_ff <= nxt_mask_std;
      mask_ext_ff <= nxt_mask_ext;
    end
  end

  // Control, status and result registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_select_low_ff      <= `CAF_MSEL_RST;
      mask_select_high_ff     <= `CAF_MSEL_RST;
      filter_accept_enable_ff <= `CAF_FEN_RST;
      for (int i = 0; i < 4; i++) begin
        bptr_ff[i] <= `CAF_BPTR_RST;
      end
      rx_buffer_full_flag_ff  <= `CAF_RXFULL_RST;
      rdata_ff                <= '0;
      accept_ff               <= 1'b0;
      reject_ff               <= 1'b0;
      filter_ff               <= '0;
      dest_ff                 <= '0;
      status_ff               <= '0;
    end else begin
      mask_select_low_ff      <= nxt_mask_select_low;
      mask_select_high_ff     <= nxt_mask_select_high;
      filter_accept_enable_ff <= nxt_filter_accept_enable;
      bptr_ff                 <= nxt_bptr;
      rx_buffer_full_flag_ff  <= nxt_rx_buffer_full_flag;
      rdata_ff                <= nxt_rdata;
      accept_ff               <= nxt_accept;
      reject_ff               <= nxt_reject;
      filter_ff               <= nxt_filter;
      dest_ff                 <= nxt_dest;
      status_ff               <= nxt_status;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_out     = rdata_ff;
  assign accept_valid_out  = accept_ff;
  assign reject_valid_out  = reject_ff;
  assign accept_filter_out = filter_ff;
  assign accept_dest_out   = dest_ff;

endmodule // caf_match

// file: verification/caf_match_assertions.sv
`timescale 1ns/1ps
`include "caf_defs.svh"
module caf_match_chk #(
  parameter int NUM_FILT = 16,
  parameter int NUM_MASK = 3
) (
  // Clock, reset, register port
  input wire logic               clk_sys_in,
  input wire logic               nrst_in,
  input wire caf_pkg::caf_addr_t reg_addr_in,
  input wire caf_pkg::caf_word_t reg_wdata_in,
  input wire logic               reg_wr_in,
  input wire logic               reg_rd_in,
  input wire caf_pkg::caf_word_t reg_rdata_out,
  // Identifier in, verdict out
  input wire logic               rx_id_valid_in,
  input wire logic [10:0]        rx_sid_in,
  input wire logic [17:0]        rx_eid_in,
  input wire logic               rx_ext_in,
  input wire logic               accept_valid_out,
  input wire logic               reject_valid_out,
  input wire caf_pkg::caf_idx_t  accept_filter_out,
  input wire caf_pkg::caf_idx_t  accept_dest_out
);
  import caf_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // Enable mirror taken off the register port; the used copy lags one edge,
  // because the filter decides with the enables standing before the valid edge
  logic [15:0] fen_mirror_ff;
  logic [15:0] fen_used_ff;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fen_mirror_ff <= `CAF_FEN_RST;
      fen_used_ff   <= `CAF_FEN_RST;
    end else begin
      if (reg_wr_in && reg_addr_in == `CAF_FEN_OFF) begin
        fen_mirror_ff <= reg_wdata_in;
      end
      fen_used_ff <= fen_mirror_ff;
    end
  end
  fen_gate_a: assert property (accept_valid_out |-> fen_used_ff[accept_filter_out]) else $error("disabled filter hit");
  // A taken identifier gets exactly one verdict, one cycle on
  sequence s_req;
    rx_id_valid_in;
  endsequence
  sequence s_ans;
    ##1 (accept_valid_out ^ reject_valid_out);
  endsequence
  resp_once_a: assert property (s_req |-> s_ans) else $error("no single verdict");
  no_both_a: assert property (!(accept_valid_out && reject_valid_out)) else $error("two verdicts");
  no_orphan_a: assert property ((accept_valid_out || reject_valid_out) |-> $past(rx_id_valid_in))
    else $error("verdict without identifier");
  // Winner and pointer only move with an accept, so software sees the last one
  filt_hold_a: assert property (!accept_valid_out |-> $stable(accept_filter_out)) else $error("filter moved");
  dest_hold_a: assert property (!accept_valid_out |-> $stable(accept_dest_out)) else $error("dest moved");
  fstd_bits_a: assert property ($past(reg_rd_in && reg_addr_in < 8'h10) |-> (reg_rdata_out & 16'h0014) == 16'h0000)
    else $error("filter word hole set");
  mstd_bits_a: assert property ($past(reg_rd_in && reg_addr_in inside {[8'h20:8'h22]}) |-> !reg_rdata_out[4]
    && !reg_rdata_out[2]) else $error("mask word hole set");
  // Pointer 1111 is the queue, never a buffer flag
  full_top_a: assert property ($past(reg_rd_in && reg_addr_in == 8'h30) |-> !reg_rdata_out[15])
    else $error("queue flag set");
endmodule // caf_match_chk
bind caf_match caf_match_chk #(.NUM_FILT(NUM_FILT), .NUM_MASK(NUM_MASK)) chk_u (.clk_sys_in, .nrst_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_id_valid_in, .rx_sid_in,
  .rx_eid_in, .rx_ext_in, .accept_valid_out, .reject_valid_out, .accept_filter_out, .accept_dest_out);

// file: verification/caf_rx_model.sv
`timescale 1ns/1ps
module caf_rx_model (
  // Clock
  input  wire logic   clk_sys_in,
  // Identifier towards the filter
  output logic        id_valid_out = 1'b0,
  output logic [10:0] sid_out = 11'h000,
  output logic [17:0] eid_out = 18'h00000,
  output logic        ext_out = 1'b0
);
  // One-cycle offer; lines then show the inverse so stale ids cannot match
  task automatic send(input logic [10:0] sid, input logic [17:0] eid, input logic ext);
    @(posedge clk_sys_in);
    id_valid_out <= 1'b1;
    sid_out <= sid;
    eid_out <= eid;
    ext_out <= ext;
    @(posedge clk_sys_in);
    id_valid_out <= 1'b0;
    sid_out <= ~sid;
    eid_out <= ~eid;
    ext_out <= ~ext;
  endtask
endmodule // caf_rx_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import caf_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  caf_addr_t   reg_addr_in = 8'h00;
  caf_word_t   reg_wdata_in = 16'h0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  caf_word_t   reg_rdata_out, rdv, fen, tmp;
  logic        rx_id_valid_in, rx_ext_in, accept_valid_out, reject_valid_out, ext;
  logic [10:0] rx_sid_in, sid;
  logic [17:0] rx_eid_in, eid;
  caf_idx_t    accept_filter_out, accept_dest_out;
  caf_word_t   fstd [16], fext [16], mstd [3], mext [3], msel [2], ptr [4];
  logic [8:0]  exp;
  logic [31:0] seed = 32'h5;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  caf_match dut_u (.clk_sys_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .rx_id_valid_in, .rx_sid_in, .rx_eid_in, .rx_ext_in, .accept_valid_out, .reject_valid_out,
    .accept_filter_out, .accept_dest_out);
  caf_rx_model rx_u (.clk_sys_in, .id_valid_out(rx_id_valid_in), .sid_out(rx_sid_in), .eid_out(rx_eid_in),
    .ext_out(rx_ext_in));
  function automatic caf_word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // Lowest enabled filter whose masked compare passes: {hit, filter, dest}
  function automatic logic [8:0] expect_hit(logic [10:0] s, logic [17:0] e, logic x);
    logic [1:0] src;
    for (int f = 0; f < 16; f++) begin
      src = msel[f/8][2*(f%8) +: 2];
      if (fen[f] && src != 2'h3 && ((s ^ fstd[f][15:5]) & mstd[src][15:5]) == 11'h000
          && ((e[17:16] ^ fstd[f][1:0]) & mstd[src][1:0]) == 2'h0 && ((e[15:0] ^ fext[f]) & mext[src]) == 16'h0000
          && (!mstd[src][3] || fstd[f][3] == x)) return {1'b1, f[3:0], ptr[f/4][4*(f%4) +: 4]};
    end
    return 9'h000;
  endfunction
  task automatic wr(caf_addr_t a, caf_word_t d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(caf_addr_t a);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 rdv = reg_rdata_out;
  endtask
  task automatic chk(caf_word_t got, caf_word_t want);
    tests_run++;
    if (got !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd(8'h28);
    chk(rdv, 16'h0000);
    rd(8'h29);
    chk(rdv, 16'h0000);
    wr(8'h05, 16'hffff);
    rd(8'h05);
    chk(rdv, 16'hffeb);
    wr(8'h21, 16'hffff);
    rd(8'h21);
    chk(rdv, 16'hffeb);
    // Random tables; sparse masks so hits and misses both occur
    for (int it = 0; it < 60; it++) begin
      for (int f = 0; f < 16; f++) begin
        fstd[f] = rnd() & 16'hffeb;
        fext[f] = rnd();
        wr(8'(f), fstd[f]);
        wr(8'(16 + f), fext[f]);
      end
      for (int m = 0; m < 3; m++) begin
        mstd[m] = rnd() & rnd() & rnd() & 16'hffeb;
        mext[m] = rnd() & rnd() & rnd();
        wr(8'(32 + m), mstd[m]);
        wr(8'(36 + m), mext[m]);
      end
      for (int p = 0; p < 4; p++) begin
        ptr[p] = rnd();
        wr(8'(44 + p), ptr[p]);
      end
      msel[0] = rnd();
      msel[1] = rnd();
      fen = rnd() | rnd();
      wr(8'h28, msel[0]);
      wr(8'h29, msel[1]);
      wr(8'h2a, fen);
      wr(8'h30, 16'h0000);
      tmp = rnd();
      ext = fstd[tmp[3:0]][3] ^ (tmp[4] & tmp[5]);
      sid = fstd[tmp[3:0]][15:5] ^ (11'(rnd()) & 11'(rnd()));
      eid = ext ? {fstd[tmp[3:0]][1:0], fext[tmp[3:0]]} : 18'h00000;
      exp = expect_hit(sid, eid, ext);
      rx_u.send(sid, eid, ext);
      #1 chk({14'h0, accept_valid_out, reject_valid_out}, {14'h0, exp[8], !exp[8]});
      if (exp[8]) begin
        chk({8'h0, accept_filter_out, accept_dest_out}, {8'h0, exp[7:0]});
        rd(8'h30);
        chk(rdv, exp[3:0] == 4'hf ? 16'h0000 : 16'h0001 << exp[3:0]);
        rd(8'h31);
        chk(rdv, {7'h00, exp});
        // Ones written to the full flags must leave them standing
        wr(8'h30, 16'hffff);
        rd(8'h30);
        chk(rdv, exp[3:0] == 4'hf ? 16'h0000 : 16'h0001 << exp[3:0]);
      end
    end
    rd(8'h3f);
    chk(rdv, 16'h0000);
    wrap_up();
  end
endmodule // tb_top
